// ### src/bssc_sram.sv
`timescale 1ns/1ns
// Overview of operation
// - inputs registered on clock, output enable asynchronous
// - array of 65536 words, 18 bits
// - counter loads and steps only low two bits
// - after four words address returns to start
// - processor start reads, abandoning burst, ignoring writes
// - controller start loads address, write if enabled
// - chip select sampled only at address load
// - advance governs cycles after first burst cycle
// - advance low increments address before access
// - advance high repeats location as wait state
// - continue cycles write when any enable low
// - byte enables gate low and high nine bits
// - write self-timed from rising clock edge
// - pins drive only on read with enable low
// - data pins high-impedance from reset
module bssc_sram (
    input  wire logic                         clk_i,
    input  wire logic                         rst_n_i,
    input  wire logic [bssc_pkg::ADDR_W-1:0]  addr_i,
    input  wire logic                         chip_enable_n_i,
    input  wire logic                         processor_transfer_start_n_i,
    input  wire logic                         controller_transfer_start_n_i,
    input  wire logic                         burst_advance_n_i,
    input  wire logic                         low_byte_write_n_i,
    input  wire logic                         high_byte_write_n_i,
    input  wire logic                         output_enable_n_i,
    input  wire logic [bssc_pkg::DATA_W-1:0]  data_io_i,
    output logic      [bssc_pkg::DATA_W-1:0]  data_io_o,
    output logic                              data_io_oe_o,
    output logic                              read_valid_o,
    input  wire logic                         read_ready_i
);
    localparam int AW = bssc_pkg::ADDR_W;
    localparam int DW = bssc_pkg::DATA_W;
    localparam int LB = bssc_pkg::BYTE_W;
    localparam int BW = bssc_pkg::BURST_W;

    // pin levels as taken on the last edge
    logic [AW-1:0]  addr_reg;
    logic           ce_n_reg;
    logic           proc_start_n_reg;
    logic           ctrl_start_n_reg;
    logic           adv_n_reg;
    logic           low_wr_n_reg;
    logic           high_wr_n_reg;
    logic [DW-1:0]  din_reg;

    // burst state
    logic [AW-1:0]  base_reg;
    logic [BW-1:0]  cnt_reg;
    logic           sel_reg;

    // read path
    logic           reading_reg;
    logic [LB-1:0]  low_rd_data;
    logic [LB-1:0]  high_rd_data;
    logic [DW-1:0]  rd_word;

    bssc_in_reg #(
        .WIDTH (AW)
    ) u_addr_in (
        .clk_i (clk_i),
        .d_i   (addr_i),
        .q_o   (addr_reg)
    );

    bssc_in_reg #(
        .WIDTH (1)
    ) u_ce_in (
        .clk_i (clk_i),
        .d_i   (chip_enable_n_i),
        .q_o   (ce_n_reg)
    );

    bssc_in_reg #(
        .WIDTH (1)
    ) u_proc_start_in (
        .clk_i (clk_i),
        .d_i   (processor_transfer_start_n_i),
        .q_o   (proc_start_n_reg)
    );

    bssc_in_reg #(
        .WIDTH (1)
    ) u_ctrl_start_in (
        .clk_i (clk_i),
        .d_i   (controller_transfer_start_n_i),
        .q_o   (ctrl_start_n_reg)
    );

    bssc_in_reg #(
        .WIDTH (1)
    ) u_adv_in (
        .clk_i (clk_i),
        .d_i   (burst_advance_n_i),
        .q_o   (adv_n_reg)
    );

    bssc_in_reg #(
        .WIDTH (1)
    ) u_low_wr_in (
        .clk_i (clk_i),
        .d_i   (low_byte_write_n_i),
        .q_o   (low_wr_n_reg)
    );

    bssc_in_reg #(
        .WIDTH (1)
    ) u_high_wr_in (
        .clk_i (clk_i),
        .d_i   (high_byte_write_n_i),
        .q_o   (high_wr_n_reg)
    );

    bssc_in_reg #(
        .WIDTH (DW)
    ) u_din_in (
        .clk_i (clk_i),
        .d_i   (data_io_i),
        .q_o   (din_reg)
    );

    // access decode from the registered pins
    wire logic          load_proc    = !proc_start_n_reg;
    wire logic          load_ctrl    = proc_start_n_reg && !ctrl_start_n_reg;
    wire logic          load         = load_proc || load_ctrl;
    wire logic          sel_now      = load ? !ce_n_reg : sel_reg;
    wire logic          any_wr       = !low_wr_n_reg || !high_wr_n_reg;
    wire logic          do_write     = sel_now && any_wr && !load_proc;
    wire logic          do_read      = sel_now && !do_write;
    wire logic          low_lane_wr  = do_write && !low_wr_n_reg;
    wire logic          high_lane_wr = do_write && !high_wr_n_reg;

    // upper bits held, low two bits counted
    wire logic [BW-1:0] cnt_step     = cnt_reg + bssc_pkg::BURST_STEP;
    wire logic [BW-1:0] cnt_cont     = adv_n_reg ? cnt_reg : cnt_step;
    wire logic [BW-1:0] cnt_now      = load ? addr_reg[BW-1:0] : cnt_cont;
    wire logic [AW-1:0] base_now     = load ? addr_reg : base_reg;
    wire logic [AW-1:0] acc_addr     = {base_now[AW-1:BW], cnt_now};

    // deselect remembered for the whole burst
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            sel_reg <= 1'h0;
        end else begin
            sel_reg <= sel_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            base_reg <= '0;
        end else begin
            base_reg <= base_now;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            reading_reg <= 1'h0;
        end else begin
            reading_reg <= do_read;
        end
    end

    bssc_byte_lane u_low_lane (
        .clk_i   (clk_i),
        .wr_en_i (low_lane_wr),
        .addr_i  (acc_addr),
        .data_i  (din_reg[LB-1:0]),
        .data_o  (low_rd_data)
    );

    bssc_byte_lane u_high_lane (
        .clk_i   (clk_i),
        .wr_en_i (high_lane_wr),
        .addr_i  (acc_addr),
        .data_i  (din_reg[DW-1:LB]),
        .data_o  (high_rd_data)
    );

    assign rd_word = {high_rd_data, low_rd_data};

    // reads arriving while both entries are held are dropped
    bssc_read_buf u_read_buf (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (do_read),
        .in_ready_o  (),
        .in_data_i   (rd_word),
        .out_valid_o (read_valid_o),
        .out_ready_i (read_ready_i),
        .out_data_o  (data_io_o)
    );

    assign data_io_oe_o = reading_reg && read_valid_o && !output_enable_n_i;
endmodule : bssc_sram

module bssc_in_reg #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    // no reset: the first edge loads the pin level
    always_ff @(posedge clk_i) begin
        q_o <= d_i;
    end
endmodule : bssc_in_reg

module bssc_byte_lane (
    input  wire logic                        clk_i,
    input  wire logic                        wr_en_i,
    input  wire logic [bssc_pkg::ADDR_W-1:0] addr_i,
    input  wire logic [bssc_pkg::BYTE_W-1:0] data_i,
    output logic      [bssc_pkg::BYTE_W-1:0] data_o
);
    logic [bssc_pkg::BYTE_W-1:0] mem [bssc_pkg::DEPTH];

    // write lands on the edge itself, no outside pulse needed
    always_ff @(posedge clk_i) begin
        if (wr_en_i) begin
            mem[addr_i] <= data_i;
        end
    end

    assign data_o = mem[addr_i];
endmodule : bssc_byte_lane

module bssc_read_buf (
    input  wire logic                        clk_i,
    input  wire logic                        rst_n_i,
    input  wire logic                        in_valid_i,
    output logic                             in_ready_o,
    input  wire logic [bssc_pkg::DATA_W-1:0] in_data_i,
    output logic                             out_valid_o,
    input  wire logic                        out_ready_i,
    output logic      [bssc_pkg::DATA_W-1:0] out_data_o
);
    logic [bssc_pkg::DATA_W-1:0] buf_reg [bssc_pkg::BUF_DEPTH];
    logic [1:0]                  count_reg;
    logic                        rd_ptr_reg;
    logic                        wr_ptr_reg;

    wire logic push = in_valid_i && in_ready_o;
    wire logic pop  = out_valid_o && out_ready_i;

    // a full buffer refuses the word
    assign in_ready_o  = count_reg != bssc_pkg::BUF_FULL;
    assign out_valid_o = count_reg != bssc_pkg::BUF_EMPTY;
    // head word stands until taken
    assign out_data_o  = out_valid_o ? buf_reg[rd_ptr_reg] : '0;

    always_ff @(posedge clk_i) begin
        if (push) begin
            buf_reg[wr_ptr_reg] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            wr_ptr_reg <= 1'h0;
        end else if (push) begin
            wr_ptr_reg <= !wr_ptr_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            rd_ptr_reg <= 1'h0;
        end else if (pop) begin
            rd_ptr_reg <= !rd_ptr_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            count_reg <= bssc_pkg::BUF_EMPTY;
        end else if (push && !pop) begin
            count_reg <= count_reg + bssc_pkg::FIFO_PTR_ONE;
        end else if (pop && !push) begin
            count_reg <= count_reg - bssc_pkg::FIFO_PTR_ONE;
        end
    end
endmodule : bssc_read_buf

// ### common/bssc_pkg.sv
package bssc_pkg;
    localparam int ADDR_W     = 16;
    localparam int DATA_W     = 18;
    localparam int BYTE_W     = 9;
    localparam int DEPTH      = 65536;
    localparam int BURST_W    = 2;
    localparam logic [1:0] BURST_STEP = 2'h1;
    localparam logic [1:0] FIFO_PTR_ONE = 2'h1;
    localparam int BUF_DEPTH = 2;
    localparam logic [1:0] BUF_FULL = 2'h2;
    localparam logic [1:0] BUF_EMPTY = 2'h0;
endpackage : bssc_pkg

// ### test/bssc_props.sv
`timescale 1ns/1ns
module bssc_props (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic chip_enable_n_i,
    input wire logic processor_transfer_start_n_i,
    input wire logic controller_transfer_start_n_i,
    input wire logic low_byte_write_n_i,
    input wire logic output_enable_n_i,
    input wire logic data_io_oe_o,
    input wire logic read_valid_o,
    input wire logic read_ready_i
);
    wire logic emp = !read_valid_o;
    wire logic sel = !chip_enable_n_i;
    wire logic pst = !processor_transfer_start_n_i;
    wire logic rdy = read_ready_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    reset_idle_a: assert property ($rose(rst_n_i) |-> emp) else $error("word after reset");
    oe_gate_a: assert property (output_enable_n_i |-> !data_io_oe_o) else $error("oe");
    oe_data_a: assert property (data_io_oe_o |-> !emp) else $error("oe while empty");
    start_read_a: assert property (emp && sel && pst |-> ##2 !emp) else $error("no read");
    desel_load_a: assert property (emp && !sel && pst ##1 rdy |=> emp) else $error("desel");
    desel_burst_a: assert property (emp && !sel && pst ##1 rdy && !pst
        && controller_transfer_start_n_i ##1 rdy |=> emp) else $error("desel burst read");
    start_write_a: assert property (emp && sel && !pst && !controller_transfer_start_n_i
        && !low_byte_write_n_i ##1 rdy |=> emp) else $error("write gave word");
    cont_write_a: assert property (emp && !pst && controller_transfer_start_n_i
        && !low_byte_write_n_i ##1 rdy |=> emp) else $error("burst write gave word");
endmodule : bssc_props
bind bssc_sram bssc_props u_props (
    .clk_i                         (clk_i),
    .rst_n_i                       (rst_n_i),
    .chip_enable_n_i               (chip_enable_n_i),
    .processor_transfer_start_n_i  (processor_transfer_start_n_i),
    .controller_transfer_start_n_i (controller_transfer_start_n_i),
    .low_byte_write_n_i            (low_byte_write_n_i),
    .output_enable_n_i             (output_enable_n_i),
    .data_io_oe_o                  (data_io_oe_o),
    .read_valid_o                  (read_valid_o),
    .read_ready_i                  (read_ready_i)
);

// ### test/bssc_bus_model.sv
`timescale 1ns/1ns
module bssc_bus_model (
    input  wire logic        clk_i,
    output logic      [40:0] bus_o
);
    initial bus_o = {7'h7f, 34'h0};
    task automatic cyc(input logic [40:0] v);
        @(posedge clk_i);
        bus_o <= v;
    endtask : cyc
endmodule : bssc_bus_model

// ### test/tb.sv
`timescale 1ns/1ns
module tb;
    logic clk_i = 0, rst_n_i = 0, read_ready_i = 1, data_io_oe_o, read_valid_o;
    logic chip_enable_n_i, processor_transfer_start_n_i, controller_transfer_start_n_i;
    logic burst_advance_n_i, low_byte_write_n_i, high_byte_write_n_i, output_enable_n_i;
    logic [15:0] addr_i;
    logic [17:0] data_io_i, data_io_o, drv, rx[$];
    logic [40:0] bus;
    int failures = 0, n_compared = 0, cycles = 0;
    bssc_sram uut (
        .clk_i                         (clk_i),
        .rst_n_i                       (rst_n_i),
        .addr_i                        (addr_i),
        .chip_enable_n_i               (chip_enable_n_i),
        .processor_transfer_start_n_i  (processor_transfer_start_n_i),
        .controller_transfer_start_n_i (controller_transfer_start_n_i),
        .burst_advance_n_i             (burst_advance_n_i),
        .low_byte_write_n_i            (low_byte_write_n_i),
        .high_byte_write_n_i           (high_byte_write_n_i),
        .output_enable_n_i             (output_enable_n_i),
        .data_io_i                     (data_io_i),
        .data_io_o                     (data_io_o),
        .data_io_oe_o                  (data_io_oe_o),
        .read_valid_o                  (read_valid_o),
        .read_ready_i                  (read_ready_i)
    );
    bssc_bus_model m (.clk_i, .bus_o(bus));
    assign {chip_enable_n_i, processor_transfer_start_n_i, controller_transfer_start_n_i,
        burst_advance_n_i, low_byte_write_n_i, high_byte_write_n_i, output_enable_n_i,
        addr_i, drv} = bus;
    assign data_io_i = data_io_oe_o ? data_io_o : drv;
    initial forever #10 clk_i = !clk_i;
    always @(posedge clk_i) if (read_valid_o && read_ready_i) rx.push_back(data_io_o);
    always @(posedge clk_i) if (++cycles >= 200) tally_and_finish();
    task automatic chk(input logic [17:0] e);
        logic [17:0] s = rx.size() ? rx.pop_front() : 'x;
        n_compared++;
        if (s !== e) failures++;
        if (s !== e) $display("unexpected read word expected %h seen %h", e, s);
    endtask : chk
    task automatic chk_oe(input logic e);
        n_compared++;
        if (data_io_oe_o !== e) failures++;
        if (data_io_oe_o !== e) $display("unexpected pin drive expected %b seen %b", e, data_io_oe_o);
    endtask : chk_oe
    task automatic t_drive;
        m.cyc({7'h1f, 16'h0100, 18'h0});
        m.cyc({7'h79, 16'h0, 18'h1c3c3});
        m.cyc({7'h1e, 16'h0100, 18'h0});
        repeat (2) m.cyc({7'h7e, 34'h0});
        #1 chk_oe(1'b1);
        m.cyc({7'h7f, 34'h0});
        #1 chk_oe(1'b0);
        idle();
        chk(18'h2);
        for (int i = 0; i < 4; i++) chk(18'h1c3c3);
    endtask : t_drive
    task automatic idle;
        m.cyc({7'h5f, 34'h0});
        repeat (3) @(posedge clk_i);
    endtask : idle
    task automatic t_bytes;
        m.cyc({7'h29, 16'h1234, 18'h2aa55});
        m.cyc({7'h2b, 16'h1234, 18'h00f0f});
        m.cyc({7'h5e, 34'h0});
        m.cyc({7'h76, 34'h0});
        m.cyc({7'h1e, 16'h1234, 18'h0});
        idle();
        chk(18'h2ab0f);
    endtask : t_bytes
    task automatic t_burst;
        m.cyc({7'h29, 16'h0102, 18'h0});
        for (int i = 1; i < 4; i++) m.cyc({7'h71, 16'h0, 18'(i)});
        m.cyc({7'h1e, 16'h0100, 18'h0});
        m.cyc({7'h7e, 34'h0});
        repeat (4) m.cyc({7'h76, 34'h0});
        idle();
        for (int i = 0; i < 6; i++) chk(18'((i + 1 + (i == 0)) % 4));
    endtask : t_burst
    task automatic t_stall;
        read_ready_i <= 0;
        m.cyc({7'h1e, 16'h0100, 18'h0});
        repeat (2) m.cyc({7'h76, 34'h0});
        idle();
        read_ready_i <= 1;
        m.cyc({7'h1e, 16'h0101, 18'h0});
        idle();
        chk(18'h2);
        chk(18'h3);
        chk(18'h3);
    endtask : t_stall
    task automatic tally_and_finish;
        if (cycles >= 200) failures++;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(posedge clk_i);
        rst_n_i <= 1;
        t_bytes();
        t_burst();
        t_stall();
        t_drive();
        tally_and_finish();
    end
endmodule : tb
